// file: fwf_consts.vh
// constants for the fault and wake flag bank
`ifndef FWF_CONSTS_VH
`define FWF_CONSTS_VH
`define FWF_FLAG_W 18
`define FWF_B_CAN_OC 0
`define FWF_B_SUSPECT 1
`define FWF_B_CONFIRM 2
`define FWF_B_LOW_BAT 3
`define FWF_B_LOW_GND 4
`define FWF_B_HIGH_BAT 5
`define FWF_B_HIGH_GND 6
`define FWF_B_PIN3_GND 7
`define FWF_B_PIN2_GND 8
`define FWF_B_PARITY 9
`define FWF_B_CS_TMO 10
`define FWF_B_SEC_UV 11
`define FWF_B_PRI_OV 12
`define FWF_B_PIN0_HOT 13
`define FWF_B_WD_HALF 14
`define FWF_B_WAKE13 15
`define FWF_B_WAKE02 16
`define FWF_B_SPI_WAKE 17
`define FWF_OFS_FLAGS 8'h00
`define FWF_OFS_INT_ST 8'h04
`define FWF_OFS_INT_MASK 8'h08
`define FWF_OFS_LIVE 8'h0C
`define FWF_FLAGS_RST 18'h00000
`define FWF_INT_RST 18'h00000
`define FWF_MASK_RST 18'h00000
`define FWF_SYNC_RST 15'h4000
// select low limit: 2 ms of the 50 MHz system clock
`define FWF_CS_LOW_CYC 17'h186A0
`endif

// file: fwf_flag_bank.v
// sticky fault and wake flag bank with ahb-lite register access
//
// Summary of operation
// - the bus overcurrent flag sets while current is over limit and clears on a read once it is gone.
// - the suspected bus fault flag sets on pre-detection and clears on a read after recovery.
// - the confirmed bus fault flag sets on full detection and clears on a read after recovery.
// - low wire short to battery and short to ground each have a flag cleared by a read after recovery.
// - high wire short to battery and short to ground each have a flag cleared by a read after recovery.
// - the pin 3 high side short to ground flag clears on a read after recovery.
// - the pin 2 high side short to ground flag clears on a read after recovery.
// - a serial parity error sets a flag that a read of the flags register clears.
// - the chip select held low past about 2 ms sets a flag that a read clears.
// - the secondary rail undervoltage flag clears on a read after the rail recovers.
// - the primary rail overvoltage flag clears on a read after the rail recovers.
// - the pin 0 high side thermal flag clears on a read after the sensor cools.
// - in flash mode a watchdog past half its period sets a flag that a read clears.
// - a wake on pin 1 or pin 3 sets a shared flag that a read clears.
// - a wake on pin 0 or pin 2 sets a shared flag that a read clears.
// - a serial wake in low power with the regulator on sets a flag that a read clears.
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "fwf_consts.vh"

module fwf_flag_bank #(
    parameter CNT_W = 17,
    parameter [CNT_W-1:0] CS_LOW_CYC = `FWF_CS_LOW_CYC,
    parameter WD_W = 16
) (
    input wire SYS_CLK,
    input wire RESET,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    output wire IRQ,
    input wire CAN_OVERCURRENT,
    input wire BUS_FAULT_SUSPECTED,
    input wire BUS_FAULT_CONFIRMED,
    input wire BUS_LOW_WIRE_BAT,
    input wire BUS_LOW_WIRE_GND,
    input wire BUS_HIGH_WIRE_BAT,
    input wire BUS_HIGH_WIRE_GND,
    input wire PIN3_HIGH_SIDE_SWITCH_GND,
    input wire PIN2_HIGH_SIDE_SWITCH_GND,
    input wire SECONDARY_SUPPLY_RAIL_UV,
    input wire PRIMARY_SUPPLY_RAIL_OV,
    input wire PIN0_HIGH_SIDE_SWITCH_HOT,
    input wire WAKE_PIN13,
    input wire WAKE_PIN02,
    input wire SERIAL_SELECT_N,
    input wire PARITY_ERROR,
    input wire SPI_WAKE,
    input wire LP_VDD_ON,
    input wire FLASH_MODE,
    input wire [WD_W-1:0] WD_ELAPSED,
    input wire [WD_W-1:0] WD_LENGTH
);

localparam FW = `FWF_FLAG_W;
localparam NS = 15;

// positions of the pins inside the synchroniser word
localparam SI_CAN_OC = 0;
localparam SI_SUSPECT = 1;
localparam SI_CONFIRM = 2;
localparam SI_LOW_BAT = 3;
localparam SI_LOW_GND = 4;
localparam SI_HIGH_BAT = 5;
localparam SI_HIGH_GND = 6;
localparam SI_PIN3_GND = 7;
localparam SI_PIN2_GND = 8;
localparam SI_SEC_UV = 9;
localparam SI_PRI_OV = 10;
localparam SI_PIN0_HOT = 11;
localparam SI_WAKE02 = 12;
localparam SI_WAKE13 = 13;
localparam SI_SEL_N = 14;

function sel;
    input [31:0] addr;
    input [7:0] ofs;
    begin
        sel = (addr[7:2] == ofs[7:2]);
    end
endfunction

function [FW-1:0] sticky;
    input [FW-1:0] cur;
    input [FW-1:0] set;
    input [FW-1:0] clr;
    begin
        // set beats clear in the same cycle
        sticky = set | (cur & ~clr);
    end
endfunction

// pin synchronisers
wire [NS-1:0] async_in;
reg [NS-1:0] sync1_ff;
reg [NS-1:0] sync2_ff;

assign async_in = {
    SERIAL_SELECT_N,
    WAKE_PIN13,
    WAKE_PIN02,
    PIN0_HIGH_SIDE_SWITCH_HOT,
    PRIMARY_SUPPLY_RAIL_OV,
    SECONDARY_SUPPLY_RAIL_UV,
    PIN2_HIGH_SIDE_SWITCH_GND,
    PIN3_HIGH_SIDE_SWITCH_GND,
    BUS_HIGH_WIRE_GND,
    BUS_HIGH_WIRE_BAT,
    BUS_LOW_WIRE_GND,
    BUS_LOW_WIRE_BAT,
    BUS_FAULT_CONFIRMED,
    BUS_FAULT_SUSPECTED,
    CAN_OVERCURRENT
};

always @(posedge SYS_CLK) begin
    if (RESET) begin
        sync1_ff <= `FWF_SYNC_RST;
        sync2_ff <= `FWF_SYNC_RST;
    end else begin
        sync1_ff <= async_in;
        sync2_ff <= sync1_ff;
    end
end

wire cs_low;
wire wake13_s;
wire wake02_s;
assign cs_low = ~sync2_ff[SI_SEL_N];
assign wake13_s = sync2_ff[SI_WAKE13];
assign wake02_s = sync2_ff[SI_WAKE02];

// condition flags follow the live detector level
wire [FW-1:0] cond_vec;
assign cond_vec[`FWF_B_CAN_OC] = sync2_ff[SI_CAN_OC];
assign cond_vec[`FWF_B_SUSPECT] = sync2_ff[SI_SUSPECT];
assign cond_vec[`FWF_B_CONFIRM] = sync2_ff[SI_CONFIRM];
assign cond_vec[`FWF_B_LOW_BAT] = sync2_ff[SI_LOW_BAT];
assign cond_vec[`FWF_B_LOW_GND] = sync2_ff[SI_LOW_GND];
assign cond_vec[`FWF_B_HIGH_BAT] = sync2_ff[SI_HIGH_BAT];
assign cond_vec[`FWF_B_HIGH_GND] = sync2_ff[SI_HIGH_GND];
assign cond_vec[`FWF_B_PIN3_GND] = sync2_ff[SI_PIN3_GND];
assign cond_vec[`FWF_B_PIN2_GND] = sync2_ff[SI_PIN2_GND];
// parity and select timeout are events and have no level
assign cond_vec[`FWF_B_PARITY] = 1'b0;
assign cond_vec[`FWF_B_CS_TMO] = 1'b0;
assign cond_vec[`FWF_B_SEC_UV] = sync2_ff[SI_SEC_UV];
assign cond_vec[`FWF_B_PRI_OV] = sync2_ff[SI_PRI_OV];
assign cond_vec[`FWF_B_PIN0_HOT] = sync2_ff[SI_PIN0_HOT];
assign cond_vec[`FWF_B_WD_HALF] = 1'b0;
assign cond_vec[`FWF_B_WAKE13] = 1'b0;
assign cond_vec[`FWF_B_WAKE02] = 1'b0;
assign cond_vec[`FWF_B_SPI_WAKE] = 1'b0;

// chip select low timer, saturates so it fires once per low period
reg [CNT_W-1:0] cs_cnt_ff;
reg [CNT_W-1:0] nxt_cs_cnt;
wire cs_tmo_pulse;

always @* begin
    nxt_cs_cnt = cs_cnt_ff;
    if (!cs_low) begin
        nxt_cs_cnt = {CNT_W{1'b0}};
    end else if (cs_cnt_ff != CS_LOW_CYC) begin
        nxt_cs_cnt = cs_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
end

always @(posedge SYS_CLK) begin
    if (RESET) begin
        cs_cnt_ff <= {CNT_W{1'b0}};
    end else begin
        cs_cnt_ff <= nxt_cs_cnt;
    end
end

assign cs_tmo_pulse = cs_low && (nxt_cs_cnt == CS_LOW_CYC) && (cs_cnt_ff != CS_LOW_CYC);

// watchdog half period, edge so a persisting state does not re-set after a read
wire wd_half_now;
reg wd_half_d_ff;
reg wake13_d_ff;
reg wake02_d_ff;

assign wd_half_now = FLASH_MODE && ({WD_ELAPSED, 1'b0} > {1'b0, WD_LENGTH});

// edge registers reset to the idle low level, so release gives no false wake
always @(posedge SYS_CLK) begin
    if (RESET) begin
        wd_half_d_ff <= 1'b0;
    end else begin
        wd_half_d_ff <= wd_half_now;
    end
end

always @(posedge SYS_CLK) begin
    if (RESET) begin
        wake13_d_ff <= 1'b0;
    end else begin
        wake13_d_ff <= wake13_s;
    end
end

always @(posedge SYS_CLK) begin
    if (RESET) begin
        wake02_d_ff <= 1'b0;
    end else begin
        wake02_d_ff <= wake02_s;
    end
end

// event flags set by one-cycle pulses, except parity and serial wake which follow their input levels
wire [FW-1:0] evt_vec;
// condition bits take no pulse
assign evt_vec[`FWF_B_CAN_OC] = 1'b0;
assign evt_vec[`FWF_B_SUSPECT] = 1'b0;
assign evt_vec[`FWF_B_CONFIRM] = 1'b0;
assign evt_vec[`FWF_B_LOW_BAT] = 1'b0;
assign evt_vec[`FWF_B_LOW_GND] = 1'b0;
assign evt_vec[`FWF_B_HIGH_BAT] = 1'b0;
assign evt_vec[`FWF_B_HIGH_GND] = 1'b0;
assign evt_vec[`FWF_B_PIN3_GND] = 1'b0;
assign evt_vec[`FWF_B_PIN2_GND] = 1'b0;
assign evt_vec[`FWF_B_PARITY] = PARITY_ERROR;
assign evt_vec[`FWF_B_CS_TMO] = cs_tmo_pulse;
assign evt_vec[`FWF_B_SEC_UV] = 1'b0;
assign evt_vec[`FWF_B_PRI_OV] = 1'b0;
assign evt_vec[`FWF_B_PIN0_HOT] = 1'b0;
assign evt_vec[`FWF_B_WD_HALF] = wd_half_now & ~wd_half_d_ff;
assign evt_vec[`FWF_B_WAKE13] = wake13_s & ~wake13_d_ff;
assign evt_vec[`FWF_B_WAKE02] = wake02_s & ~wake02_d_ff;
assign evt_vec[`FWF_B_SPI_WAKE] = SPI_WAKE & LP_VDD_ON;

wire [FW-1:0] set_vec;
assign set_vec = cond_vec | evt_vec;

// ahb-lite slave; reads are sampled in the address phase, so no wait states
wire acc;
wire rd_acc;
wire rd_flags;
reg wr_pend_ff;
reg [7:0] wr_addr_ff;
reg [31:0] hrdata_ff;
reg [31:0] nxt_hrdata;

assign acc = HSEL && HREADY && HTRANS[1];
assign rd_acc = acc && !HWRITE;
assign rd_flags = rd_acc && sel(HADDR, `FWF_OFS_FLAGS);

always @(posedge SYS_CLK) begin
    if (RESET) begin
        wr_pend_ff <= 1'b0;
    end else begin
        wr_pend_ff <= acc && HWRITE;
    end
end

// address kept for the data phase that follows a taken transfer
always @(posedge SYS_CLK) begin
    if (RESET) begin
        wr_addr_ff <= 8'h00;
    end else if (acc) begin
        wr_addr_ff <= HADDR[7:0];
    end
end

wire wr_int_st;
wire wr_mask;
assign wr_int_st = wr_pend_ff && sel({24'h000000, wr_addr_ff}, `FWF_OFS_INT_ST);
assign wr_mask = wr_pend_ff && sel({24'h000000, wr_addr_ff}, `FWF_OFS_INT_MASK);

// flag bank; condition flags re-set each cycle the condition holds
reg [FW-1:0] flags_ff;
reg [FW-1:0] int_st_ff;
reg [FW-1:0] mask_ff;
reg irq_ff;
wire [FW-1:0] nxt_flags;
wire [FW-1:0] nxt_int_st;
wire [FW-1:0] rd_clr;
wire [FW-1:0] w1c;

assign rd_clr = {FW{rd_flags}};
assign nxt_flags = sticky(flags_ff, set_vec, rd_clr);
assign w1c = wr_int_st ? HWDATA[FW-1:0] : {FW{1'b0}};
// a flag that is already set does not raise the interrupt again
wire [FW-1:0] rise_vec;
wire [FW-1:0] nxt_mask;
wire nxt_irq;
assign rise_vec = set_vec & ~flags_ff;
assign nxt_int_st = sticky(int_st_ff, rise_vec, w1c);
// a mask write reaches the irq in the same cycle as a status update
assign nxt_mask = wr_mask ? HWDATA[FW-1:0] : mask_ff;
assign nxt_irq = |(nxt_int_st & nxt_mask);

always @(posedge SYS_CLK) begin
    if (RESET) begin
        flags_ff <= `FWF_FLAGS_RST;
    end else begin
        flags_ff <= nxt_flags;
    end
end

always @(posedge SYS_CLK) begin
    if (RESET) begin
        int_st_ff <= `FWF_INT_RST;
    end else begin
        int_st_ff <= nxt_int_st;
    end
end

always @(posedge SYS_CLK) begin
    if (RESET) begin
        mask_ff <= `FWF_MASK_RST;
    end else begin
        mask_ff <= nxt_mask;
    end
end

always @(posedge SYS_CLK) begin
    if (RESET) begin
        irq_ff <= 1'b0;
    end else begin
        irq_ff <= nxt_irq;
    end
end

// read mux; unmapped offsets read zero
always @* begin
    nxt_hrdata = hrdata_ff;
    if (rd_acc) begin
        nxt_hrdata = 32'h00000000;
        if (sel(HADDR, `FWF_OFS_FLAGS)) begin
            nxt_hrdata[FW-1:0] = flags_ff;
        end
        if (sel(HADDR, `FWF_OFS_INT_ST)) begin
            nxt_hrdata[FW-1:0] = int_st_ff;
        end
        if (sel(HADDR, `FWF_OFS_INT_MASK)) begin
            nxt_hrdata[FW-1:0] = mask_ff;
        end
        if (sel(HADDR, `FWF_OFS_LIVE)) begin
            nxt_hrdata[FW-1:0] = cond_vec;
        end
        if (HADDR[7:4] != 4'h0) begin
            nxt_hrdata = 32'h00000000;
        end
    end
end

always @(posedge SYS_CLK) begin
    if (RESET) begin
        hrdata_ff <= 32'h00000000;
    end else begin
        hrdata_ff <= nxt_hrdata;
    end
end

assign HRDATA = hrdata_ff;
assign HREADYOUT = 1'b1;
assign HRESP = 1'b0;
assign IRQ = irq_ff;

endmodule

// file: fwf_flag_bank_chk.sv
// assertions on the flag bank ports
`timescale 1ns/100ps
module fwf_flag_bank_chk (
    input wire SYS_CLK,
    input wire RESET,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire HREADY,
    input wire [31:0] HRDATA,
    input wire HREADYOUT,
    input wire HRESP,
    input wire CAN_OVERCURRENT,
    input wire BUS_FAULT_SUSPECTED,
    input wire SECONDARY_SUPPLY_RAIL_UV,
    input wire PARITY_ERROR,
    input wire SPI_WAKE,
    input wire LP_VDD_ON
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    wire rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
    wire rdf = rd && HADDR[7:2] == 6'h00;
    reg par_ff;
    reg wake_ff;
    // an event seen since the last flag read must show at the next one
    always @(posedge SYS_CLK) begin
        par_ff <= !RESET && (PARITY_ERROR || (par_ff && !rdf));
        wake_ff <= !RESET && ((SPI_WAKE && LP_VDD_ON) || (wake_ff && !rdf));
    end
    sequence rd_flags;
        rdf;
    endsequence
    oc_kept_a: assert property (CAN_OVERCURRENT [*4] ##0 rd_flags |=> HRDATA[0])
        else $error("overcurrent flag missing");
    susp_kept_a: assert property (BUS_FAULT_SUSPECTED [*4] ##0 rd_flags |=> HRDATA[1])
        else $error("suspected fault flag missing");
    uv_kept_a: assert property (SECONDARY_SUPPLY_RAIL_UV [*4] ##0 rd_flags |=> HRDATA[11])
        else $error("undervoltage flag missing");
    par_seen_a: assert property (par_ff ##0 rd_flags |=> HRDATA[9])
        else $error("parity flag missing");
    spi_wake_a: assert property (wake_ff ##0 rd_flags |=> HRDATA[17])
        else $error("serial wake flag missing");
    data_hold_a: assert property (!rd |=> $stable(HRDATA))
        else $error("read data changed without a read");
    resp_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus response not okay");
    upper_zero_a: assert property (rd |=> HRDATA[31:18] == 14'h0000)
        else $error("unused read bits not zero");
endmodule

// file: fwf_host_model.sv
// host serial frame model: select low for a set time, then a parity or wake pulse
`timescale 1ns/100ps
module fwf_host_model (
    input wire clk,
    input wire start,
    input wire bad,
    input wire [7:0] len,
    output reg sel_n = 1'b1,
    output reg par_err = 1'b0,
    output reg spi_wake = 1'b0
);
    reg [7:0] cnt_ff = 8'h00;
    // pulses last one cycle so each frame sets a flag once
    always @(posedge clk) begin
        par_err <= 1'b0;
        spi_wake <= 1'b0;
        if (start) begin
            cnt_ff <= len;
            sel_n <= 1'b0;
        end else if (cnt_ff > 8'h01) begin
            cnt_ff <= cnt_ff - 8'h01;
        end else if (!sel_n) begin
            sel_n <= 1'b1;
            par_err <= bad;
            spi_wake <= !bad;
        end
    end
endmodule

// file: fault_wake_flag_latches_tb.sv
// self-checking bench for the flag bank
`timescale 1ns/100ps
module fault_wake_flag_latches_tb;
    reg SYS_CLK = 1'b0;
    reg RESET = 1'b1;
    reg [31:0] HADDR = 32'h00000000;
    reg [1:0] HTRANS = 2'h0;
    reg HWRITE = 1'b0;
    reg [31:0] HWDATA = 32'h00000000;
    reg [11:0] cond = 12'h000;
    reg [1:0] wake = 2'h0;
    reg LP_VDD_ON = 1'b0;
    reg FLASH_MODE = 1'b0;
    reg [15:0] WD_ELAPSED = 16'h0000;
    reg start = 1'b0;
    reg bad = 1'b0;
    reg [7:0] len = 8'h03;
    reg [31:0] q;
    wire [31:0] HRDATA;
    wire HREADYOUT, HRESP, IRQ, sel_n, par_err, spi_wake;
    integer num_errors = 0;
    integer checks_done = 0;
    integer cycles = 0;
    always #10 SYS_CLK = ~SYS_CLK;
    // short select timeout keeps the run brief
    fwf_flag_bank #(.CS_LOW_CYC(17'h00014)) fwf_flag_bank_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(1'b1),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .CAN_OVERCURRENT(cond[0]),
        .BUS_FAULT_SUSPECTED(cond[1]), .BUS_FAULT_CONFIRMED(cond[2]), .BUS_LOW_WIRE_BAT(cond[3]),
        .BUS_LOW_WIRE_GND(cond[4]), .BUS_HIGH_WIRE_BAT(cond[5]), .BUS_HIGH_WIRE_GND(cond[6]),
        .PIN3_HIGH_SIDE_SWITCH_GND(cond[7]), .PIN2_HIGH_SIDE_SWITCH_GND(cond[8]),
        .SECONDARY_SUPPLY_RAIL_UV(cond[9]), .PRIMARY_SUPPLY_RAIL_OV(cond[10]),
        .PIN0_HIGH_SIDE_SWITCH_HOT(cond[11]), .WAKE_PIN13(wake[0]), .WAKE_PIN02(wake[1]),
        .SERIAL_SELECT_N(sel_n), .PARITY_ERROR(par_err), .SPI_WAKE(spi_wake), .LP_VDD_ON(LP_VDD_ON),
        .FLASH_MODE(FLASH_MODE), .WD_ELAPSED(WD_ELAPSED), .WD_LENGTH(16'h0064));
    fwf_host_model fwf_host_model_i (.clk(SYS_CLK), .start(start), .bad(bad), .len(len), .sel_n(sel_n),
        .par_err(par_err), .spi_wake(spi_wake));
    task chk(input [31:0] seen, input [31:0] exp, input string nm);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %0s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task bus(input w, input [7:0] a, input [31:0] d);
        HTRANS <= 2'h2;
        HADDR <= {24'h000000, a};
        HWRITE <= w;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge SYS_CLK);
        while (HREADYOUT !== 1'b1) @(posedge SYS_CLK);
        q = HRDATA;
    endtask
    task rd(input [7:0] a, input [31:0] exp, input string nm);
        bus(1'b0, a, 32'h00000000);
        chk(q, exp, nm);
    endtask
    task frame(input [7:0] l, input b);
        start <= 1'b1;
        len <= l;
        bad <= b;
        @(posedge SYS_CLK);
        start <= 1'b0;
        repeat (l + 4) @(posedge SYS_CLK);
    endtask
    task irq_path;
        rd(8'h08, 32'h00000000, "mask reset");
        bus(1'b1, 8'h40, 32'h0003FFFF);
        bus(1'b1, 8'h04, 32'h0003FFFF);
        bus(1'b1, 8'h08, 32'h00000200);
        repeat (2) @(posedge SYS_CLK);
        #1 chk(IRQ, 32'h0, "irq idle");
        @(posedge SYS_CLK);
        rd(8'h08, 32'h00000200, "mask back");
        rd(8'h40, 32'h00000000, "unmapped");
        frame(8'h03, 1'b1);
        #1 chk(IRQ, 32'h1, "irq raised");
        @(posedge SYS_CLK);
        rd(8'h04, 32'h00000200, "int status");
        bus(1'b1, 8'h04, 32'h00000200);
        repeat (2) @(posedge SYS_CLK);
        #1 chk(IRQ, 32'h0, "irq cleared");
        @(posedge SYS_CLK);
        rd(8'h00, 32'h00000200, "parity once");
    endtask
    task cond_flags;
        cond <= 12'hFFF;
        repeat (5) @(posedge SYS_CLK);
        rd(8'h00, 32'h000039FF, "cond set");
        rd(8'h00, 32'h000039FF, "cond held");
        rd(8'h0C, 32'h000039FF, "live set");
        cond <= 12'h000;
        repeat (5) @(posedge SYS_CLK);
        rd(8'h0C, 32'h00000000, "live clear");
        rd(8'h00, 32'h000039FF, "cond sticky");
        rd(8'h00, 32'h00000000, "cond clear");
    endtask
    task event_flags;
        LP_VDD_ON <= 1'b1;
        frame(8'h1E, 1'b1);
        frame(8'h03, 1'b0);
        wake <= 2'h3;
        repeat (6) @(posedge SYS_CLK);
        rd(8'h00, 32'h00038600, "events set");
        rd(8'h00, 32'h00000000, "events clear");
        LP_VDD_ON <= 1'b0;
        wake <= 2'h0;
        frame(8'h03, 1'b0);
        rd(8'h00, 32'h00000000, "wake gated");
    endtask
    task wd_flag;
        FLASH_MODE <= 1'b1;
        WD_ELAPSED <= 16'h0032;
        repeat (3) @(posedge SYS_CLK);
        rd(8'h00, 32'h00000000, "wd at half");
        WD_ELAPSED <= 16'h0033;
        repeat (3) @(posedge SYS_CLK);
        rd(8'h00, 32'h00004000, "wd past half");
        rd(8'h00, 32'h00000000, "wd cleared");
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge SYS_CLK) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            end_of_test;
        end
    end
    initial begin
        repeat (4) @(posedge SYS_CLK);
        RESET <= 1'b0;
        @(posedge SYS_CLK);
        irq_path;
        cond_flags;
        event_flags;
        wd_flag;
        end_of_test;
    end
endmodule
bind fwf_flag_bank fwf_flag_bank_chk fwf_flag_bank_chk_i (.SYS_CLK(SYS_CLK), .RESET(RESET), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .CAN_OVERCURRENT(CAN_OVERCURRENT), .BUS_FAULT_SUSPECTED(BUS_FAULT_SUSPECTED),
    .SECONDARY_SUPPLY_RAIL_UV(SECONDARY_SUPPLY_RAIL_UV), .PARITY_ERROR(PARITY_ERROR), .SPI_WAKE(SPI_WAKE),
    .LP_VDD_ON(LP_VDD_ON));
